// ### src/sipo_pkg.sv
/*
 package of the serial-in parallel-out latch block: widths and carrier types.
 assumes a single clock domain (mclk) shared by all users.
*/
package sipo_pkg;
	localparam int STAGES = 8;
	localparam int CASCADE_STAGE = 7;
	localparam logic [7:0] PAR_RESET = 8'h00;
	localparam logic SER_RESET = 1'h0;
	localparam int BUF_DEPTH = 2;

	typedef struct packed {
		logic serial_data;
		logic strobe;
		logic output_enable;
	} sipo_ctl_t;

	typedef struct packed {
		logic [7:0] parallel_out;
		logic [7:0] parallel_oe;
	} sipo_par_t;
endpackage

// ### src/sipo_buf.sv
/*
 two-entry buffer with valid and ready on both sides.
 assumes synchronous active-low reset on mclk.
*/
module sipo_buf #(
	parameter int WIDTH = 16,
	parameter int DEPTH = sipo_pkg::BUF_DEPTH
) (
	input wire logic mclk,
	input wire logic resetn,
	input wire logic [WIDTH-1:0] in_data,
	input wire logic in_valid,
	output logic in_ready,
	output logic [WIDTH-1:0] out_data,
	output logic out_valid,
	input wire logic out_ready
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	logic [WIDTH-1:0] mem_ff [DEPTH];
	logic [WIDTH-1:0] nxt_mem [DEPTH];
	logic [AW-1:0] wr_ff, nxt_wr, rd_ff, nxt_rd;
	logic [AW:0] cnt_ff, nxt_cnt;
	logic push, pop;

	always_comb begin
		push = in_valid && in_ready;
		pop = out_valid && out_ready;
		nxt_mem = mem_ff;
		nxt_wr = wr_ff;
		nxt_rd = rd_ff;
		if (push) begin
			nxt_mem[wr_ff] = in_data;
			nxt_wr = (wr_ff == AW'(DEPTH - 1)) ? '0 : wr_ff + 1'b1;
		end
		if (pop) begin
			nxt_rd = (rd_ff == AW'(DEPTH - 1)) ? '0 : rd_ff + 1'b1;
		end
		nxt_cnt = cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
	end

	always_ff @(posedge mclk) begin
		if (!resetn) begin
			wr_ff <= '0;
			rd_ff <= '0;
			cnt_ff <= '0;
		end else begin
			wr_ff <= nxt_wr;
			rd_ff <= nxt_rd;
			cnt_ff <= nxt_cnt;
		end
		mem_ff <= nxt_mem;
	end

	assign in_ready = (cnt_ff != (AW+1)'(DEPTH));
	assign out_valid = (cnt_ff != '0);
	assign out_data = mem_ff[rd_ff];
endmodule

// ### src/sipo_latch.sv
/*
 serial-in parallel-out shift register with storage latches and
 enabled parallel outputs, plus rising and falling cascade outputs.
 assumes the shift clock, strobe and enable arrive on the mclk domain
 as a stream of control words; the parallel pins are resolved outside
 from the output enables.
*/
// Summary of operation
// - each shift step moves serial data into stage one and every stage up.
// - each shift step copies stage seven into stage eight and the fast out.
// - the slow cascade out takes stage seven on the following falling edge.
// - latches follow the stages while strobe is high and hold when low.
// - parallel outputs are released when enable is low, driven when high.
module sipo_latch #(
	parameter int STAGES = sipo_pkg::STAGES
) (
	input wire logic mclk,
	input wire logic resetn,
	input wire logic shift_clk,
	input wire sipo_pkg::sipo_ctl_t ctl,
	input wire logic ctl_valid,
	output logic ctl_ready,
	output logic [STAGES-1:0] parallel_out,
	output logic [STAGES-1:0] parallel_oe,
	output logic serial_out_rising,
	output logic serial_out_falling,
	output logic par_valid,
	input wire logic par_ready
);
	typedef struct packed {
		logic shift_clk;
		sipo_pkg::sipo_ctl_t ctl;
	} sipo_word_t;

	sipo_word_t buf_out;
	logic buf_valid, buf_ready;
	logic [STAGES-1:0] chain_ff, nxt_chain;
	logic [STAGES-1:0] latch_ff, nxt_latch;
	logic [STAGES-1:0] par_ff, nxt_par, oe_ff, nxt_oe;
	logic clk_prev_ff, nxt_clk_prev;
	logic fast_ff, nxt_fast, slow_ff, nxt_slow;
	logic pv_ff, nxt_pv;
	logic rise, fall, take;

	sipo_buf #(
		.WIDTH($bits(sipo_word_t)),
		.DEPTH(sipo_pkg::BUF_DEPTH)
	) u_buf (
		.mclk(mclk),
		.resetn(resetn),
		.in_data({shift_clk, ctl}),
		.in_valid(ctl_valid),
		.in_ready(ctl_ready),
		.out_data(buf_out),
		.out_valid(buf_valid),
		.out_ready(buf_ready)
	);

	assign buf_ready = !pv_ff || par_ready;

	always_comb begin
		take = buf_valid && buf_ready;
		rise = take && buf_out.shift_clk && !clk_prev_ff;
		fall = take && !buf_out.shift_clk && clk_prev_ff;
		nxt_clk_prev = take ? buf_out.shift_clk : clk_prev_ff;
		nxt_chain = chain_ff;
		nxt_fast = fast_ff;
		nxt_slow = slow_ff;
		if (rise) begin
			nxt_chain = {chain_ff[STAGES-2:0], buf_out.ctl.serial_data};
			nxt_fast = chain_ff[sipo_pkg::CASCADE_STAGE-1];
		end
		if (fall) begin
			nxt_slow = chain_ff[sipo_pkg::CASCADE_STAGE-1];
		end
		nxt_latch = latch_ff;
		nxt_par = par_ff;
		nxt_oe = oe_ff;
		nxt_pv = pv_ff && !par_ready;
		if (take) begin
			if (buf_out.ctl.strobe) begin
				nxt_latch = nxt_chain;
			end
			nxt_par = nxt_latch;
			nxt_oe = {STAGES{buf_out.ctl.output_enable}};
			nxt_pv = 1'b1;
		end
	end

	always_ff @(posedge mclk) begin
		if (!resetn) begin
			clk_prev_ff <= sipo_pkg::SER_RESET;
			fast_ff <= sipo_pkg::SER_RESET;
			slow_ff <= sipo_pkg::SER_RESET;
			par_ff <= STAGES'(sipo_pkg::PAR_RESET);
			oe_ff <= STAGES'(sipo_pkg::PAR_RESET);
			latch_ff <= STAGES'(sipo_pkg::PAR_RESET);
			pv_ff <= 1'b0;
		end else begin
			clk_prev_ff <= nxt_clk_prev;
			fast_ff <= nxt_fast;
			slow_ff <= nxt_slow;
			par_ff <= nxt_par;
			oe_ff <= nxt_oe;
			latch_ff <= nxt_latch;
			pv_ff <= nxt_pv;
		end
		chain_ff <= nxt_chain;
	end

	assign parallel_out = par_ff;
	assign parallel_oe = oe_ff;
	assign serial_out_rising = fast_ff;
	assign serial_out_falling = slow_ff;
	assign par_valid = pv_ff;

	shift_fast_a: assert property (@(posedge mclk) disable iff (!resetn)
		rise |=> serial_out_rising === $past(chain_ff[6]))
		else $error("fast cascade out missed stage seven");
	shift_in_a: assert property (@(posedge mclk) disable iff (!resetn)
		rise |=> chain_ff[0] == $past(buf_out.ctl.serial_data))
		else $error("serial data not shifted in");
	slow_hold_a: assert property (@(posedge mclk) disable iff (!resetn)
		!fall |=> serial_out_falling === $past(serial_out_falling))
		else $error("slow cascade out moved off a falling edge");
	slow_take_a: assert property (@(posedge mclk) disable iff (!resetn)
		fall |=> serial_out_falling === $past(chain_ff[6]))
		else $error("slow cascade out missed stage seven");
	latch_hold_a: assert property (@(posedge mclk) disable iff (!resetn)
		(take && !buf_out.ctl.strobe) |=> latch_ff === $past(latch_ff))
		else $error("latch changed while strobe low");
	oe_off_a: assert property (@(posedge mclk) disable iff (!resetn)
		(take && !buf_out.ctl.output_enable) |=> parallel_oe == '0)
		else $error("parallel outputs driven while disabled");
	oe_on_a: assert property (@(posedge mclk) disable iff (!resetn)
		(take && buf_out.ctl.output_enable) |=> (&parallel_oe))
		else $error("parallel outputs not driven while enabled");
	cascade_free_a: assert property (@(posedge mclk) disable iff (!resetn)
		(rise && !buf_out.ctl.strobe && !buf_out.ctl.output_enable)
		|=> serial_out_rising === $past(chain_ff[6]))
		else $error("cascade out stopped by strobe or enable");
endmodule

// ### tb/sipo_host.sv
/*
 host model: offers sampled pin words to the latch block.
 assumes mclk from the bench; drives after falling edges.
*/
module sipo_host (
	input wire logic mclk,
	input wire logic ctl_ready,
	output logic shift_clk,
	output sipo_pkg::sipo_ctl_t ctl,
	output logic ctl_valid
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		shift_clk = 1'h0;
		ctl = 3'h0;
		ctl_valid = 1'h0;
	end
	task automatic put(input logic c, input logic [2:0] w);
		int n;
		@(negedge mclk);
		shift_clk = c;
		ctl = w;
		ctl_valid = 1'h1;
		n = 0;
		while (!ctl_ready && n < 50) begin
			@(negedge mclk);
			n++;
		end
		@(posedge mclk);
	endtask
	task automatic rest();
		@(negedge mclk);
		ctl_valid = 1'h0;
		ctl = ~ctl;
		repeat (4) @(negedge mclk);
	endtask
endmodule

// ### tb/serial_in_parallel_out_latch_tb.sv
/*
 bench of the latch block: shifts bytes through the host model.
 assumes a bounded two-word buffer latency, checked after idle gaps.
*/
module serial_in_parallel_out_latch_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic mclk, resetn, par_ready, shift_clk, ctl_valid, ctl_ready;
	logic sor, sof, par_valid;
	sipo_pkg::sipo_ctl_t ctl;
	logic [7:0] pout, poe, ch, lat;
	int fail_count, comparisons, primed;
	sipo_latch i_dut (.mclk(mclk), .resetn(resetn), .shift_clk(shift_clk),
		.ctl(ctl), .ctl_valid(ctl_valid), .ctl_ready(ctl_ready),
		.parallel_out(pout), .parallel_oe(poe), .serial_out_rising(sor),
		.serial_out_falling(sof), .par_valid(par_valid),
		.par_ready(par_ready));
	sipo_host i_host (.mclk(mclk), .ctl_ready(ctl_ready),
		.shift_clk(shift_clk), .ctl(ctl), .ctl_valid(ctl_valid));
	initial begin
		mclk = 1'h0;
		forever #2 mclk = ~mclk;
	end
	task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			fail_count++;
			$display("Error %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic give_verdict();
		$display("comparisons %0d fail_count %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	task automatic pulse(input logic d, input logic s, input logic e);
		logic old;
		i_host.put(1'h0, {d, s, e});
		i_host.rest();
		if (primed >= 8) cmp(sof, ch[6]);
		old = ch[6];
		i_host.put(1'h1, {d, s, e});
		i_host.rest();
		ch = {ch[6:0], d};
		if (s) lat = ch;
		primed++;
		if (primed >= 8) begin
			cmp(sor, old);
			cmp(sof, old);
			cmp(pout, lat);
		end
		cmp(poe, {8{e}});
	endtask
	task automatic shift_byte(input logic [7:0] b, input logic s,
		input logic e);
		for (int i = 7; i >= 0; i--) pulse(b[i], s, e);
		$display("byte %h done", b);
	endtask
	task automatic t_hold();
		shift_byte(8'h3C, 1'h0, 1'h1);
		cmp(pout, 8'hA5);
	endtask
	task automatic t_stall();
		par_ready = 1'h0;
		fork
			begin
				repeat (12) @(negedge mclk);
				cmp({7'h00, par_valid}, 8'h01);
				par_ready = 1'h1;
			end
		join_none
		i_host.put(1'h0, 3'h7);
		i_host.put(1'h1, 3'h7);
		i_host.put(1'h0, 3'h1);
		i_host.put(1'h1, 3'h1);
		i_host.rest();
		repeat (12) @(negedge mclk);
		ch = {ch[6:0], 1'h1};
		lat = ch;
		ch = {ch[6:0], 1'h0};
		cmp(pout, lat);
		cmp(sor, ch[7]);
		cmp(sof, ch[7]);
		$display("stall done");
	endtask
	initial begin
		#20000;
		fail_count++;
		give_verdict();
	end
	initial begin
		resetn = 1'h0;
		par_ready = 1'h1;
		ch = 8'hxx;
		lat = 8'h00;
		repeat (8) @(negedge mclk);
		resetn = 1'h1;
		cmp(pout, 8'h00);
		shift_byte(8'hA5, 1'h1, 1'h1);
		t_hold();
		shift_byte(8'h96, 1'h1, 1'h0);
		t_stall();
		give_verdict();
	end
endmodule
